//--- design/cfd_decoder.sv
// Summary of operation
// - Fetch and decode one 14-bit word each.
// - Classify into byte, bit, literal/control.
// - Plain instructions take one instruction cycle.
// - Both call forms take two cycles.
// - All three return forms take two cycles.
// - Jumps, branches, taken skips take two cycles.
// - Indirect access to program memory adds cycle.
// - One instruction cycle is four clocks.
// - File operand read before any write back.
// - Destination bit 0 accumulator, 1 file.
// - File address field is seven bits.
// - Bit index field is three bits.
// - General literal is low eight bits.
// - Call and jump target is eleven bits.
// - Page latch literal is seven bits.
// - Five-bit literal format in low bits.
// - Relative branch offset is nine bits.
// - Pointer offset: select plus six-bit offset.
// - Pointer step: select plus two-bit mode.
// - Select chooses pointer zero or one.
// - Don't-care bits never change the operation.
// - Second cycle of two-cycle ops is idle.
module cfd_decoder (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [cfd_pkg::WORD_W-1:0] instr_i,
  input wire logic skip_true_i,
  input wire logic [cfd_pkg::PTR_N-1:0] ptr_msb_i,
  output logic fetch_req_o,
  output cfd_pkg::cfd_op_type op_o,
  output cfd_pkg::cfd_group_type group_o,
  output cfd_pkg::cfd_fields_type fields_o,
  output logic ptr_sel_o,
  output logic [1:0] phase_o,
  output cfd_pkg::cfd_state_type cycle_state_o,
  output logic read_stb_o,
  output logic write_file_o,
  output logic write_acc_o,
  output logic skip_taken_o
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic cfd_pkg::cfd_op_type op_lookup(input logic [cfd_pkg::WORD_W-1:0] w);
    cfd_pkg::cfd_op_type res;
    logic hit;
    res = cfd_pkg::OP_ILLEGAL;
    hit = 1'b0;
    for (int i = 0; i < cfd_pkg::PAT_N; i++) begin
      if (!hit && ((w & cfd_pkg::PAT_TABLE[i].mask) == cfd_pkg::PAT_TABLE[i].match)) begin
        res = cfd_pkg::PAT_TABLE[i].op;
        hit = 1'b1;
      end
    end
    return res;
  endfunction : op_lookup

  function automatic cfd_pkg::cfd_group_type op_group(input cfd_pkg::cfd_op_type op);
    if (op inside {[cfd_pkg::OP_ADD_ACC_F:cfd_pkg::OP_INC_SKIP_ZERO]}) begin
      return cfd_pkg::GRP_BYTE;
    end else if (op inside {[cfd_pkg::OP_BIT_CLR:cfd_pkg::OP_SKIP_IF_BIT_SET]}) begin
      return cfd_pkg::GRP_BIT;
    end else begin
      return cfd_pkg::GRP_LIT_CTRL;
    end
  endfunction : op_group

  function automatic logic refs_file(input cfd_pkg::cfd_op_type op);
    return (op_group(op) != cfd_pkg::GRP_LIT_CTRL) && (op != cfd_pkg::OP_CLR_ACC);
  endfunction : refs_file

  function automatic logic writes_file(input cfd_pkg::cfd_op_type op, input logic dest);
    return ((op_group(op) == cfd_pkg::GRP_BYTE) && (dest == cfd_pkg::DEST_FILE)) ||
           (op inside {cfd_pkg::OP_BIT_CLR, cfd_pkg::OP_BIT_SET});
  endfunction : writes_file

  function automatic logic is_skip(input cfd_pkg::cfd_op_type op);
    return op inside {cfd_pkg::OP_DEC_SKIP_ZERO, cfd_pkg::OP_INC_SKIP_ZERO,
                      cfd_pkg::OP_SKIP_IF_BIT_CLEAR, cfd_pkg::OP_SKIP_IF_BIT_SET};
  endfunction : is_skip

  function automatic logic is_call(input cfd_pkg::cfd_op_type op);
    return op inside {cfd_pkg::OP_CALL, cfd_pkg::OP_CALL_VIA_ACC};
  endfunction : is_call

  function automatic logic is_return(input cfd_pkg::cfd_op_type op);
    return op inside {cfd_pkg::OP_RETURN, cfd_pkg::OP_RETURN_WITH_LITERAL,
                      cfd_pkg::OP_RETURN_FROM_INTERRUPT};
  endfunction : is_return

  function automatic logic is_jump(input cfd_pkg::cfd_op_type op);
    return op inside {cfd_pkg::OP_JUMP, cfd_pkg::OP_RELATIVE_BRANCH,
                      cfd_pkg::OP_BRANCH_VIA_ACC};
  endfunction : is_jump

  function automatic logic is_ptr_mem(input cfd_pkg::cfd_op_type op);
    return op inside {cfd_pkg::OP_PTR_LOAD_STEP, cfd_pkg::OP_PTR_STORE_STEP,
                      cfd_pkg::OP_PTR_LOAD_OFF, cfd_pkg::OP_PTR_STORE_OFF};
  endfunction : is_ptr_mem

  function automatic logic is_step(input cfd_pkg::cfd_op_type op);
    return op inside {cfd_pkg::OP_PTR_LOAD_STEP, cfd_pkg::OP_PTR_STORE_STEP};
  endfunction : is_step

  // ----------------------------------------------------------------
  // Phase counter and field slicing
  // ----------------------------------------------------------------
  logic [1:0] phase;
  cfd_pkg::cfd_fields_type new_fields;

  cfd_phase_gen u_phase (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .phase_o(phase)
  );

  cfd_field_split u_split (
    .word_i(instr_i),
    .fields_o(new_fields)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  cfd_pkg::cfd_op_type op_reg;
  cfd_pkg::cfd_group_type group_reg;
  cfd_pkg::cfd_fields_type fields_reg;
  logic ptr_sel_reg;
  cfd_pkg::cfd_state_type state_reg;
  cfd_pkg::cfd_state_type state_next;
  logic fetch_req_reg;
  logic read_stb_reg;
  logic write_file_reg;
  logic write_acc_reg;
  logic skip_taken_reg;
  logic ind_pend_reg;
  logic nop_pend_reg;

  // ----------------------------------------------------------------
  // Named decode wires
  // ----------------------------------------------------------------
  wire logic at_decode = (phase == cfd_pkg::PHASE_DECODE);
  wire logic at_modify = (phase == cfd_pkg::PHASE_MODIFY);
  wire logic at_last = (phase == cfd_pkg::PHASE_LAST);
  wire logic in_exec = (state_reg == cfd_pkg::ST_EXEC);
  wire logic word_take = fetch_req_reg && at_last;
  wire cfd_pkg::cfd_op_type new_op = op_lookup(instr_i);
  wire cfd_pkg::cfd_group_type new_group = op_group(new_op);
  wire logic new_ptr_sel = is_step(new_op) ? new_fields.step_sel :
                           new_fields.off_sel;
  wire logic addr_is_port = (fields_reg.file_addr == cfd_pkg::IND_PORT0_ADDR) ||
                            (fields_reg.file_addr == cfd_pkg::IND_PORT1_ADDR);
  wire logic port_to_prog = refs_file(op_reg) && addr_is_port &&
                            ptr_msb_i[fields_reg.file_addr[0]];
  wire logic ptr_to_prog = is_ptr_mem(op_reg) && ptr_msb_i[ptr_sel_reg];
  wire logic ind_need = port_to_prog || ptr_to_prog;
  wire logic skip_hit = is_skip(op_reg) && skip_true_i;
  wire logic nop_need = is_call(op_reg) || is_return(op_reg) ||
                        is_jump(op_reg) || skip_hit;
  wire logic exec_done = !ind_need && !nop_need;
  wire logic will_exec = in_exec ? exec_done :
                         (state_reg == cfd_pkg::ST_IND) ? !nop_pend_reg : 1'b1;

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (at_last) begin
      case (state_reg)
        cfd_pkg::ST_EXEC: begin
          if (ind_pend_reg) begin
            state_next = cfd_pkg::ST_IND;
          end else if (nop_pend_reg) begin
            state_next = cfd_pkg::ST_NOP;
          end else begin
            state_next = cfd_pkg::ST_EXEC;
          end
        end
        cfd_pkg::ST_IND: begin
          state_next = nop_pend_reg ? cfd_pkg::ST_NOP : cfd_pkg::ST_EXEC;
        end
        cfd_pkg::ST_NOP: begin
          state_next = cfd_pkg::ST_EXEC;
        end
        default: begin
          state_next = cfd_pkg::ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= cfd_pkg::ST_EXEC;
      ind_pend_reg <= 1'b0;
      nop_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (at_modify && in_exec) begin
        ind_pend_reg <= ind_need;
        nop_pend_reg <= nop_need;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fetch and decoded word
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_req_reg <= 1'b0;
    end else begin
      fetch_req_reg <= at_modify && will_exec;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_reg <= cfd_pkg::OP_NOP;
      group_reg <= cfd_pkg::GRP_LIT_CTRL;
      fields_reg <= '0;
      ptr_sel_reg <= 1'b0;
    end else if (word_take) begin
      op_reg <= new_op;
      group_reg <= new_group;
      fields_reg <= new_fields;
      ptr_sel_reg <= new_ptr_sel;
    end
  end

  // ----------------------------------------------------------------
  // Register file strobes, idle in extra cycles
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_stb_reg <= 1'b0;
      write_file_reg <= 1'b0;
      write_acc_reg <= 1'b0;
    end else begin
      read_stb_reg <= at_decode && in_exec && refs_file(op_reg);
      write_file_reg <= at_modify && in_exec &&
                        writes_file(op_reg, fields_reg.dest_file);
      write_acc_reg <= at_modify && in_exec && (group_reg == cfd_pkg::GRP_BYTE) &&
                       (fields_reg.dest_file == cfd_pkg::DEST_ACC);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      skip_taken_reg <= 1'b0;
    end else if (at_modify && in_exec) begin
      skip_taken_reg <= skip_hit;
    end else if (word_take) begin
      skip_taken_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fetch_req_o = fetch_req_reg;
  assign op_o = op_reg;
  assign group_o = group_reg;
  assign fields_o = fields_reg;
  assign ptr_sel_o = ptr_sel_reg;
  assign phase_o = phase;
  assign cycle_state_o = state_reg;
  assign read_stb_o = read_stb_reg;
  assign write_file_o = write_file_reg;
  assign write_acc_o = write_acc_reg;
  assign skip_taken_o = skip_taken_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [1:0] extra_cnt_reg;
  logic ind_seen_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      extra_cnt_reg <= cfd_pkg::EXTRA_NONE;
      ind_seen_reg <= 1'b0;
    end else if (word_take) begin
      extra_cnt_reg <= cfd_pkg::EXTRA_NONE;
      ind_seen_reg <= 1'b0;
    end else if (at_last) begin
      extra_cnt_reg <= extra_cnt_reg + 2'h1;
      ind_seen_reg <= ind_seen_reg || (state_next == cfd_pkg::ST_IND);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking

  default disable iff (!arst_n_i);

  AST_PHASE_WRAP: assert property (
    (phase_o == cfd_pkg::PHASE_LAST) |=> (phase_o == cfd_pkg::PHASE_DECODE) ##1
      (phase_o == cfd_pkg::PHASE_READ) ##1 (phase_o == cfd_pkg::PHASE_MODIFY)
  ) else $error("instruction cycle not four clocks");

  AST_WORD_TAKEN: assert property (
    fetch_req_o |-> (phase_o == cfd_pkg::PHASE_LAST) ##1
      (fields_o.lit11 == $past(instr_i[10:0])) && (op_o == op_lookup($past(instr_i)))
  ) else $error("word not taken at end of fetch cycle");

  AST_GROUP_KNOWN: assert property (
    group_o inside {cfd_pkg::GRP_BYTE, cfd_pkg::GRP_BIT, cfd_pkg::GRP_LIT_CTRL} &&
    (group_o == op_group(op_o))
  ) else $error("group does not match operation");

  AST_PLAIN_ONE: assert property (
    fetch_req_o && (group_o == cfd_pkg::GRP_BYTE) && !is_skip(op_o) && !ind_seen_reg
      |-> (extra_cnt_reg == cfd_pkg::EXTRA_NONE)
  ) else $error("plain instruction took extra cycles");

  AST_CALL_TWO: assert property (
    fetch_req_o && is_call(op_o) |-> (extra_cnt_reg == cfd_pkg::EXTRA_ONE)
  ) else $error("call not two cycles");

  AST_RETURN_TWO: assert property (
    fetch_req_o && is_return(op_o) |-> (extra_cnt_reg == cfd_pkg::EXTRA_ONE)
  ) else $error("return not two cycles");

  AST_BRANCH_TWO: assert property (
    fetch_req_o && (is_jump(op_o) || skip_taken_o) && !ind_seen_reg
      |-> (extra_cnt_reg == cfd_pkg::EXTRA_ONE)
  ) else $error("branch or taken skip not two cycles");

  AST_IND_EXTRA: assert property (
    fetch_req_o && ind_seen_reg && (group_o == cfd_pkg::GRP_BYTE) && !is_skip(op_o)
      |-> (extra_cnt_reg == cfd_pkg::EXTRA_ONE)
  ) else $error("indirect program access missing extra cycle");

  AST_READ_FIRST: assert property (
    write_file_o |-> $past(read_stb_o, 2) && (cycle_state_o == cfd_pkg::ST_EXEC)
  ) else $error("write back without earlier read");

  AST_DEST_ROUTE: assert property (
    write_acc_o |-> !write_file_o && (fields_o.dest_file == cfd_pkg::DEST_ACC) &&
      (group_o == cfd_pkg::GRP_BYTE)
  ) else $error("accumulator write with file destination");

  AST_EXTRA_IDLE: assert property (
    (cycle_state_o != cfd_pkg::ST_EXEC) |-> !read_stb_o && !write_file_o && !write_acc_o
  ) else $error("strobe in extra cycle");

endmodule : cfd_decoder

//--- shared/cfd_pkg.sv
package cfd_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int FILE_LSB = 0;
  localparam int FILE_W = 7;
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int BIT_W = 3;
  localparam int LIT_LSB = 0;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int LIT7_W = 7;
  localparam int LIT5_W = 5;
  localparam int LIT9_W = 9;
  localparam int OFF_SEL_POS = 6;
  localparam int OFF_W = 6;
  localparam int STEP_SEL_POS = 2;
  localparam int STEP_W = 2;
  localparam int PTR_N = 2;

  localparam logic [FILE_W-1:0] FILE_MIN = 7'h00;
  localparam logic [FILE_W-1:0] FILE_MAX = 7'h7f;
  localparam logic [FILE_W-1:0] IND_PORT0_ADDR = 7'h00;
  localparam logic [FILE_W-1:0] IND_PORT1_ADDR = 7'h01;
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] PHASE_DECODE = 2'h0;
  localparam logic [1:0] PHASE_READ = 2'h1;
  localparam logic [1:0] PHASE_MODIFY = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1);
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GRP_BYTE = 2'h0,
    GRP_BIT = 2'h1,
    GRP_LIT_CTRL = 2'h2
  } cfd_group_type;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_IND = 2'h1,
    ST_NOP = 2'h3
  } cfd_state_type;

  typedef enum logic [5:0] {
    OP_ADD_ACC_F, OP_ADDC_ACC_F, OP_AND_ACC_F, OP_ASHR_F, OP_SHL_F, OP_SHR_F,
    OP_CLR_F, OP_CLR_ACC, OP_INV_F, OP_DEC_F, OP_INC_F, OP_OR_ACC_F, OP_MOV_F,
    OP_MOV_ACC_F, OP_ROL_F, OP_ROR_F, OP_SUB_ACC_F, OP_SUBB_ACC_F, OP_SWAP_F,
    OP_XOR_ACC_F, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
    OP_BIT_CLR, OP_BIT_SET, OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET,
    OP_NOP, OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT, OP_MOV_LIT_BANK, OP_LOAD_PAGE_LATCH,
    OP_MOV_LIT, OP_SUB_LIT, OP_XOR_LIT, OP_RELATIVE_BRANCH, OP_BRANCH_VIA_ACC,
    OP_CALL, OP_CALL_VIA_ACC, OP_JUMP, OP_RETURN_FROM_INTERRUPT,
    OP_RETURN_WITH_LITERAL, OP_RETURN, OP_PTR_ADD, OP_PTR_LOAD_STEP,
    OP_PTR_STORE_STEP, OP_PTR_LOAD_OFF, OP_PTR_STORE_OFF, OP_ILLEGAL
  } cfd_op_type;

  typedef struct packed {
    logic [FILE_W-1:0] file_addr;
    logic dest_file;
    logic [BIT_W-1:0] bit_idx;
    logic [LIT8_W-1:0] lit8;
    logic [LIT11_W-1:0] lit11;
    logic [LIT7_W-1:0] lit7;
    logic [LIT5_W-1:0] lit5;
    logic [LIT9_W-1:0] lit9;
    logic off_sel;
    logic [OFF_W-1:0] off6;
    logic step_sel;
    logic [STEP_W-1:0] step_mode;
  } cfd_fields_type;

  typedef struct packed {
    logic [WORD_W-1:0] mask;
    logic [WORD_W-1:0] match;
    cfd_op_type op;
  } cfd_pat_type;

  // ----------------------------------------------------------------
  // Opcode table, first match wins
  // ----------------------------------------------------------------
  localparam int PAT_N = 48;
  localparam cfd_pat_type PAT_TABLE [PAT_N] = '{
    '{14'h3fff, 14'h0000, OP_NOP}, '{14'h3fff, 14'h0008, OP_RETURN},
    '{14'h3fff, 14'h0009, OP_RETURN_FROM_INTERRUPT},
    '{14'h3fff, 14'h000a, OP_CALL_VIA_ACC}, '{14'h3fff, 14'h000b, OP_BRANCH_VIA_ACC},
    '{14'h3ff8, 14'h0010, OP_PTR_LOAD_STEP}, '{14'h3ff8, 14'h0018, OP_PTR_STORE_STEP},
    '{14'h3fe0, 14'h0020, OP_MOV_LIT_BANK}, '{14'h3f80, 14'h0080, OP_MOV_ACC_F},
    '{14'h3ffc, 14'h0100, OP_CLR_ACC}, '{14'h3f80, 14'h0180, OP_CLR_F},
    '{14'h3f00, 14'h0200, OP_SUB_ACC_F}, '{14'h3f00, 14'h0300, OP_DEC_F},
    '{14'h3f00, 14'h0400, OP_OR_ACC_F}, '{14'h3f00, 14'h0500, OP_AND_ACC_F},
    '{14'h3f00, 14'h0600, OP_XOR_ACC_F}, '{14'h3f00, 14'h0700, OP_ADD_ACC_F},
    '{14'h3f00, 14'h0800, OP_MOV_F}, '{14'h3f00, 14'h0900, OP_INV_F},
    '{14'h3f00, 14'h0a00, OP_INC_F}, '{14'h3f00, 14'h0b00, OP_DEC_SKIP_ZERO},
    '{14'h3f00, 14'h0c00, OP_ROR_F}, '{14'h3f00, 14'h0d00, OP_ROL_F},
    '{14'h3f00, 14'h0e00, OP_SWAP_F}, '{14'h3f00, 14'h0f00, OP_INC_SKIP_ZERO},
    '{14'h3f00, 14'h3500, OP_SHL_F}, '{14'h3f00, 14'h3600, OP_SHR_F},
    '{14'h3f00, 14'h3700, OP_ASHR_F}, '{14'h3f00, 14'h3b00, OP_SUBB_ACC_F},
    '{14'h3f00, 14'h3d00, OP_ADDC_ACC_F},
    '{14'h3c00, 14'h1000, OP_BIT_CLR}, '{14'h3c00, 14'h1400, OP_BIT_SET},
    '{14'h3c00, 14'h1800, OP_SKIP_IF_BIT_CLEAR}, '{14'h3c00, 14'h1c00, OP_SKIP_IF_BIT_SET},
    '{14'h3800, 14'h2000, OP_CALL}, '{14'h3800, 14'h2800, OP_JUMP},
    '{14'h3f00, 14'h3000, OP_MOV_LIT}, '{14'h3f00, 14'h3800, OP_OR_LIT},
    '{14'h3f00, 14'h3900, OP_AND_LIT}, '{14'h3f00, 14'h3a00, OP_XOR_LIT},
    '{14'h3f00, 14'h3c00, OP_SUB_LIT}, '{14'h3f00, 14'h3e00, OP_ADD_LIT},
    '{14'h3f00, 14'h3400, OP_RETURN_WITH_LITERAL},
    '{14'h3f80, 14'h3100, OP_PTR_ADD}, '{14'h3f80, 14'h3180, OP_LOAD_PAGE_LATCH},
    '{14'h3f80, 14'h3f00, OP_PTR_LOAD_OFF}, '{14'h3f80, 14'h3f80, OP_PTR_STORE_OFF},
    '{14'h3e00, 14'h3200, OP_RELATIVE_BRANCH}
  };

endpackage : cfd_pkg

//--- design/cfd_phase_gen.sv
module cfd_phase_gen (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  output logic [1:0] phase_o
);

  // ----------------------------------------------------------------
  // Four oscillator periods per instruction cycle
  // ----------------------------------------------------------------
  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  assign phase_next = (phase_reg == cfd_pkg::PHASE_LAST) ? cfd_pkg::PHASE_DECODE :
                      phase_reg + 2'h1;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_reg <= cfd_pkg::PHASE_DECODE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_o = phase_reg;

endmodule : cfd_phase_gen

//--- design/cfd_field_split.sv
module cfd_field_split (
  input wire logic [cfd_pkg::WORD_W-1:0] word_i,
  output cfd_pkg::cfd_fields_type fields_o
);

  // ----------------------------------------------------------------
  // Operand fields of every format
  // ----------------------------------------------------------------
  assign fields_o.file_addr = word_i[cfd_pkg::FILE_LSB +: cfd_pkg::FILE_W];
  assign fields_o.dest_file = word_i[cfd_pkg::DEST_POS];
  assign fields_o.bit_idx = word_i[cfd_pkg::BIT_LSB +: cfd_pkg::BIT_W];
  assign fields_o.lit8 = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::LIT8_W];
  assign fields_o.lit11 = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::LIT11_W];
  assign fields_o.lit7 = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::LIT7_W];
  assign fields_o.lit5 = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::LIT5_W];
  assign fields_o.lit9 = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::LIT9_W];
  assign fields_o.off_sel = word_i[cfd_pkg::OFF_SEL_POS];
  assign fields_o.off6 = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::OFF_W];
  assign fields_o.step_sel = word_i[cfd_pkg::STEP_SEL_POS];
  assign fields_o.step_mode = word_i[cfd_pkg::LIT_LSB +: cfd_pkg::STEP_W];

endmodule : cfd_field_split

//--- verif/cfd_prog_mem.sv
module cfd_prog_mem (
  input wire logic fetch_req_i,
  input wire logic [cfd_pkg::WORD_W-1:0] word_i,
  output logic [cfd_pkg::WORD_W-1:0] instr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Whole word only while fetched, inverted pattern otherwise
  assign instr_o = fetch_req_i ? word_i : ~word_i;
endmodule : cfd_prog_mem

//--- verif/cfd_decoder_tb.sv
module cfd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, arst_n_i, skip_true_i, fetch_req_o, ptr_sel_o;
  logic read_stb_o, write_file_o, write_acc_o, skip_taken_o;
  logic [1:0] ptr_msb_i, phase_o;
  logic [13:0] word, instr_i;
  cfd_pkg::cfd_op_type op_o;
  cfd_pkg::cfd_group_type group_o;
  cfd_pkg::cfd_fields_type fields_o;
  cfd_pkg::cfd_state_type cycle_state_o;
  int n_mismatch, checked, clks, n_rd, n_wf, n_wa, n_idle, n_ind;
  cfd_decoder uut (.ref_clk_i, .arst_n_i, .instr_i, .skip_true_i, .ptr_msb_i, .fetch_req_o,
    .op_o, .group_o, .fields_o, .ptr_sel_o, .phase_o, .cycle_state_o, .read_stb_o,
    .write_file_o, .write_acc_o, .skip_taken_o);
  cfd_prog_mem mem (.fetch_req_i(fetch_req_o), .word_i(word), .instr_o(instr_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] strb();
    return {4'(n_rd), 4'(n_wf), 4'(n_wa), 4'(n_idle)};
  endfunction : strb
  // Runs one word, measuring clocks from its take to the next take
  task automatic exec(input logic [13:0] w, input logic sk, input logic [1:0] pm, input int ec);
    int n;
    @(posedge ref_clk_i);
    word <= w;
    skip_true_i <= sk;
    ptr_msb_i <= pm;
    n = 0;
    clks = 0;
    n_rd = 0;
    n_wf = 0;
    n_wa = 0;
    n_idle = 0;
    n_ind = 0;
    @(negedge ref_clk_i);
    while (fetch_req_o !== 1'b1 || n < 4) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 30) begin
        n_mismatch++;
        final_report();
      end
    end
    do begin
      @(negedge ref_clk_i);
      clks++;
      n_rd += int'(read_stb_o === 1'b1);
      n_wf += int'(write_file_o === 1'b1);
      n_wa += int'(write_acc_o === 1'b1);
      n_idle += int'(cycle_state_o === cfd_pkg::ST_NOP);
      n_ind += int'(cycle_state_o === cfd_pkg::ST_IND);
      if (clks > 30) begin
        n_mismatch++;
        final_report();
      end
    end while (fetch_req_o !== 1'b1);
    chk(clks, ec);
    chk(phase_o, cfd_pkg::PHASE_LAST);
  endtask : exec
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic byte_ops;
    exec(14'h07a5, 1'b0, 2'h0, 4);
    chk(op_o, cfd_pkg::OP_ADD_ACC_F);
    chk(group_o, cfd_pkg::GRP_BYTE);
    chk({fields_o.file_addr, fields_o.dest_file}, {7'h25, 1'b1});
    chk(strb(), 16'h1100);
    exec(14'h0725, 1'b0, 2'h0, 4);
    chk(strb(), 16'h1010);
    exec(14'h01ff, 1'b0, 2'h0, 4);
    chk({fields_o.file_addr, strb()}, {7'h7f, 16'h1100});
  endtask : byte_ops
  task automatic bit_lit;
    exec(14'h1725, 1'b0, 2'h0, 4);
    chk(group_o, cfd_pkg::GRP_BIT);
    chk({fields_o.bit_idx, fields_o.file_addr}, {3'h6, 7'h25});
    exec(14'h305a, 1'b0, 2'h0, 4);
    chk({group_o, fields_o.lit8}, {cfd_pkg::GRP_LIT_CTRL, 8'h5a});
    exec(14'h31d5, 1'b0, 2'h0, 4);
    chk({op_o, fields_o.lit7}, {cfd_pkg::OP_LOAD_PAGE_LATCH, 7'h55});
    exec(14'h0035, 1'b0, 2'h0, 4);
    chk(fields_o.lit5, 5'h15);
    exec(14'h0103, 1'b0, 2'h0, 4);
    chk(op_o, cfd_pkg::OP_CLR_ACC);
    exec(14'h0040, 1'b0, 2'h0, 4);
    chk({op_o, strb()}, {cfd_pkg::OP_ILLEGAL, 16'h0000});
  endtask : bit_lit
  task automatic two_cycle;
    logic [13:0] w [6] = '{14'h000a, 14'h2abc, 14'h000b, 14'h0008, 14'h3412, 14'h0009};
    foreach (w[i]) begin
      exec(w[i], 1'b0, 2'h0, 8);
      chk(strb(), 16'h0004);
    end
    exec(14'h2123, 1'b0, 2'h0, 8);
    chk(fields_o.lit11, 11'h123);
    exec(14'h3345, 1'b0, 2'h0, 8);
    chk(fields_o.lit9, 9'h145);
  endtask : two_cycle
  task automatic skips;
    exec(14'h1825, 1'b1, 2'h0, 8);
    chk(skip_taken_o, 1'b1);
    exec(14'h1c25, 1'b0, 2'h0, 4);
    exec(14'h0ba5, 1'b1, 2'h0, 8);
    chk(strb(), 16'h1104);
    exec(14'h0fa5, 1'b0, 2'h0, 4);
  endtask : skips
  task automatic indirect;
    exec(14'h0880, 1'b0, 2'h1, 8);
    chk(n_ind, cfd_pkg::OSC_PER_INSTR);
    exec(14'h0880, 1'b0, 2'h2, 4);
    chk(n_ind, 0);
    exec(14'h0881, 1'b0, 2'h2, 8);
    exec(14'h0b80, 1'b1, 2'h1, 12);
    chk(n_ind, cfd_pkg::OSC_PER_INSTR);
    chk(strb(), 16'h1104);
    exec(14'h3f45, 1'b0, 2'h2, 8);
    chk({ptr_sel_o, fields_o.off_sel, fields_o.off6}, {2'h3, 6'h05});
    exec(14'h0016, 1'b0, 2'h0, 4);
    chk({ptr_sel_o, fields_o.step_sel, fields_o.step_mode}, {2'h3, 2'h2});
    exec(14'h001f, 1'b0, 2'h2, 8);
    chk(op_o, cfd_pkg::OP_PTR_STORE_STEP);
  endtask : indirect
  initial begin
    arst_n_i = 1'b0;
    skip_true_i = 1'b0;
    ptr_msb_i = 2'h0;
    word = 14'h0000;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    byte_ops();
    bit_lit();
    two_cycle();
    skips();
    indirect();
    final_report();
  end
endmodule : cfd_decoder_tb
